// >>> src/result_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   // Filling side.
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Draining side.
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   // Fill level.
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   wire [CNT_W-1:0] next_level = level_o + CNT_W'(push) - CNT_W'(pop);

   // Storage is only written, never reset, so it stays plain flip-flops.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and flags; ready and valid come from registered level state.
   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level_o <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         wr_ptr <= push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
         rd_ptr <= pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
         level_o <= next_level;
         in_ready_o <= (next_level != CNT_W'(DEPTH));
         out_valid_o <= (next_level != '0);
      end
   end

   assign out_data_o = mem[rd_ptr];
endmodule
`default_nettype wire

// >>> src/sinc_decimation_filter.sv
// Functional notes
// R1: A modulator sample is taken once every four master clock cycles.
// R2: The fixed stage is a fifth-order sinc decimating by 64, one result every 256 cycles.
// R3: The second stage averages fixed-stage results over the count chosen by the rate code.
// R4: Final words appear every 256 times the averaging count master clock cycles.
// R5: Codes F0, E0, D0 and C0 select 1 (bypassed), 2, 4 and 8 averages.
// R6: Codes B0, A1, 92 and 82 select 15, 30, 60 and 300 averages.
// R7: Codes 72, 63, 53 and 43 select 500, 600, 1000 and 1200 averages.
// R8: Codes 33, 23, 13 and 03 select 2000, 3000, 6000 and 12000 averages.
// R9: All output timing is counted from the master clock alone.
// R10: During self gain calibration all mux switches open and each reference pin feeds its internal input.
// R11: After a sync the ready output stays inactive until a fully settled word exists.
// R12: A rate code write clears the averager and restarts its count.
`timescale 1ns/10ps
`default_nettype none
module sinc_decimation_filter
   import sinc_filter_pkg::*;
(
   // Master clock and reset.
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Modulator and sync pin.
   input wire logic mod_bit_i,
   input wire logic sync_powerdown_pin_i,
   // Avalon-MM slave.
   input wire logic [sinc_filter_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Result stream.
   output logic [sinc_filter_pkg::WORD_W-1:0] result_data_o,
   output logic result_valid_o,
   input wire logic result_ready_i,
   output logic result_ready_n_o,
   // Calibration routing.
   output logic mux_all_open_o,
   output logic route_neg_ref_to_neg_in_o,
   output logic route_pos_ref_to_pos_in_o
);
   import sinc_filter_pkg::*;

   // ------------------------------------------------------------------
   // Register bus.
   // ------------------------------------------------------------------
   logic [7:0] rate_code_field;
   logic cal_en;
   logic soft_sync;
   logic overrun;
   logic rejected;
   logic [WORD_W-1:0] last_result;
   logic fifo_in_ready;
   logic [LEVEL_W-1:0] fifo_level;
   logic [2:0] warm_cnt;

   wire bus_req = avs_read_i || avs_write_i;
   wire acc_wr = avs_write_i && !avs_waitrequest_o;
   wire acc_rd = avs_read_i && !avs_waitrequest_o;
   wire wr_rate = acc_wr && (avs_address_i == OFF_RATE);
   wire wr_ctrl = acc_wr && (avs_address_i == OFF_CTRL);
   wire rd_status = acc_rd && (avs_address_i == OFF_STATUS);
   wire [AVG_W-1:0] new_avg = avg_count(avs_writedata_i[7:0]);
   wire rate_accept = wr_rate && (new_avg != '0);
   wire [AVG_W-1:0] num_avg = avg_count(rate_code_field);
   wire cic_settled = (warm_cnt == 3'(CIC_ORDER));
   wire [31:0] status_word;
   wire [31:0] next_readdata;

   assign status_word = (32'(fifo_level) << ST_LEVEL_LSB)
                      | (32'(cic_settled) << ST_SETTLED_BIT)
                      | (32'(rejected) << ST_REJECT_BIT)
                      | (32'(overrun) << ST_OVERRUN_BIT)
                      | (32'(!result_ready_n_o) << ST_READY_BIT);
   assign next_readdata = (avs_address_i == OFF_RATE) ? 32'(rate_code_field)
                        : (avs_address_i == OFF_CTRL) ? ((32'(soft_sync) << CTRL_SYNC_BIT)
                                                        | (32'(cal_en) << CTRL_CAL_BIT))
                        : (avs_address_i == OFF_STATUS) ? status_word
                        : (avs_address_i == OFF_RESULT) ? 32'(last_result)
                        : 32'h0000_0000;

   // Every access waits exactly one cycle; read data is captured while waiting.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
         if (bus_req && avs_waitrequest_o) begin
            avs_readdata_o <= next_readdata;
         end
      end
   end

   // Invalid rate codes are refused so the averager never sees a zero count.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rate_code_field <= RATE_RESET;
         rejected <= 1'b0;
         cal_en <= 1'b0;
         soft_sync <= 1'b0;
      end else begin
         if (rate_accept) begin
            rate_code_field <= avs_writedata_i[7:0]; // R5 R6 R7 R8
         end
         if (wr_rate) begin
            rejected <= !rate_accept;
         end
         if (wr_ctrl) begin
            cal_en <= avs_writedata_i[CTRL_CAL_BIT];
            soft_sync <= avs_writedata_i[CTRL_SYNC_BIT];
         end
      end
   end

   // Calibration routing is taken straight from the control flop.
   assign mux_all_open_o = cal_en; // R10
   assign route_neg_ref_to_neg_in_o = cal_en; // R10
   assign route_pos_ref_to_pos_in_o = cal_en; // R10

   // ------------------------------------------------------------------
   // Fixed sinc stage.
   // ------------------------------------------------------------------
   wire restart = sync_powerdown_pin_i || soft_sync;
   wire avg_clear = restart || rate_accept;
   logic [1:0] div_cnt;
   logic [5:0] dec_cnt;
   wire sample_en = (div_cnt == 2'(SAMPLE_DIV - 1));
   wire cic_tick = sample_en && (dec_cnt == 6'(DECIM - 1));

   // Both dividers run from the master clock only, so all rates scale with it.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || restart) begin
         div_cnt <= 2'h0;
         dec_cnt <= 6'h00;
         warm_cnt <= 3'h0;
      end else begin
         div_cnt <= 2'(div_cnt + 2'h1); // R1 R9
         if (sample_en) begin
            dec_cnt <= 6'(dec_cnt + 6'h01); // R2
         end
         if (cic_tick && !cic_settled) begin
            warm_cnt <= 3'(warm_cnt + 3'h1);
         end
      end
   end

   // Integrators and combs wrap modulo 2^CIC_W; the output is still exact.
   logic [CIC_W-1:0] integ [CIC_ORDER];
   logic [CIC_W-1:0] comb_dly [CIC_ORDER];
   wire [CIC_W-1:0] integ_src [CIC_ORDER];
   wire [CIC_W-1:0] comb_val [CIC_ORDER+1];
   assign comb_val[0] = integ[CIC_ORDER-1];

   for (genvar g = 0; g < CIC_ORDER; g++) begin : g_stage
      if (g == 0) begin : g_first
         assign integ_src[g] = CIC_W'(mod_bit_i);
      end else begin : g_next
         assign integ_src[g] = integ[g-1];
      end
      assign comb_val[g+1] = comb_val[g] - comb_dly[g];
      always_ff @(posedge ref_clk_i) begin
         if (sys_rst_i || restart) begin
            integ[g] <= '0;
            comb_dly[g] <= '0;
         end else begin
            if (sample_en) begin
               integ[g] <= integ[g] + integ_src[g]; // R2
            end
            if (cic_tick) begin
               comb_dly[g] <= comb_val[g]; // R2
            end
         end
      end
   end

   wire [CIC_W-1:0] cic_out = comb_val[CIC_ORDER];

   // ------------------------------------------------------------------
   // Averager and divider.
   // ------------------------------------------------------------------
   logic [ACC_W-1:0] avg_sum;
   logic [AVG_W-1:0] avg_cnt;
   div_state_t state;
   logic [ACC_W-1:0] quot;
   logic [AVG_W:0] rem;
   logic [STEP_W-1:0] step;
   wire cic_take = cic_tick && cic_settled;
   wire avg_last = (avg_cnt == AVG_W'(num_avg - 14'h0001));
   wire avg_latch = cic_take && avg_last;
   wire [ACC_W-1:0] sum_total = avg_sum + ACC_W'(cic_out);
   wire [AVG_W:0] rem_shift = {rem[AVG_W-1:0], quot[ACC_W-1]};
   wire rem_ge = (rem_shift >= {1'b0, num_avg});
   wire [AVG_W:0] rem_next = rem_ge ? (AVG_W+1)'(rem_shift - {1'b0, num_avg}) : rem_shift;
   wire push_done = (state == ST_PUSH) && fifo_in_ready;

   // The accumulator restarts on sync and on any accepted rate code.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || avg_clear) begin
         avg_sum <= '0; // R12
         avg_cnt <= '0; // R12
      end else if (cic_take) begin
         avg_sum <= avg_last ? '0 : sum_total; // R3
         avg_cnt <= avg_last ? '0 : AVG_W'(avg_cnt + 14'h0001); // R3 R4
      end
   end

   // A restoring divider turns the sum into the mean; 44 steps fit well inside 256 cycles.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || avg_clear) begin
         state <= ST_IDLE;
         quot <= '0;
         rem <= '0;
         step <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (avg_latch) begin
                  quot <= (num_avg == 14'h0001) ? ACC_W'(cic_out) : sum_total; // R5
                  rem <= '0;
                  step <= '0;
                  state <= (num_avg == 14'h0001) ? ST_PUSH : ST_DIVIDE;
               end
            end
            ST_DIVIDE: begin
               quot <= {quot[ACC_W-2:0], rem_ge};
               rem <= rem_next;
               step <= STEP_W'(step + 6'h01);
               if (step == STEP_W'(ACC_W - 1)) begin
                  state <= ST_PUSH;
               end
            end
            ST_PUSH: begin
               if (fifo_in_ready) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // When a result cannot leave before the next one is due, the new one is dropped and flagged.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         overrun <= 1'b0;
         last_result <= '0;
         result_ready_n_o <= 1'b1;
      end else begin
         overrun <= (avg_latch && state != ST_IDLE) || (overrun && !rd_status);
         if (push_done) begin
            last_result <= quot[WORD_W-1:0];
         end
         result_ready_n_o <= restart || !result_valid_o; // R11
      end
   end

   // ------------------------------------------------------------------
   // Output buffer.
   // ------------------------------------------------------------------
   result_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(ref_clk_i),
      .rst_i(sys_rst_i),
      .flush_i(restart),
      .in_data_i(quot[WORD_W-1:0]),
      .in_valid_i(state == ST_PUSH),
      .in_ready_o(fifo_in_ready),
      .out_data_o(result_data_o),
      .out_valid_o(result_valid_o),
      .out_ready_i(result_ready_i),
      .level_o(fifo_level)
   );

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------
   logic [GAP_W-1:0] gap_cnt;
   logic gap_seen;
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || avg_clear) begin
         gap_cnt <= '0;
         gap_seen <= 1'b0;
      end else begin
         gap_cnt <= avg_latch ? GAP_W'(1) : GAP_W'(gap_cnt + 1'b1);
         gap_seen <= gap_seen || avg_latch;
      end
   end

   property p_sample_rate;
      @(posedge ref_clk_i) disable iff (sys_rst_i || restart)
      sample_en |=> !sample_en [*3] ##1 sample_en;
   endproperty
   a_sample_rate: assert property (p_sample_rate) else $error("sample spacing wrong"); // R1
   property p_fixed_rate;
      @(posedge ref_clk_i) disable iff (sys_rst_i || restart)
      cic_tick |-> ##256 cic_tick;
   endproperty
   a_fixed_rate: assert property (p_fixed_rate) else $error("fixed stage period wrong"); // R2
   property p_avg_bound;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      cic_take |-> avg_cnt < num_avg;
   endproperty
   a_avg_bound: assert property (p_avg_bound) else $error("average count overrun"); // R3
   property p_out_rate;
      @(posedge ref_clk_i) disable iff (sys_rst_i || avg_clear)
      (avg_latch && gap_seen) |-> gap_cnt == GAP_W'({num_avg, 8'h00});
   endproperty
   a_out_rate: assert property (p_out_rate) else $error("output word period wrong"); // R4
   // A rate write in the latch cycle aborts the word on purpose, so it must not count here.
   property p_code_fast;
      @(posedge ref_clk_i) disable iff (sys_rst_i || avg_clear)
      (avg_latch && rate_code_field == CODE_A1 && state == ST_IDLE) |=> state == ST_PUSH;
   endproperty
   a_code_fast: assert property (p_code_fast) else $error("bypass code not bypassed"); // R5
   property p_code_mid;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rate_code_field == CODE_A300) |-> num_avg == 14'h012C;
   endproperty
   a_code_mid: assert property (p_code_mid) else $error("code 82 decode wrong"); // R6
   property p_code_slow;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rate_code_field == CODE_A1200) |-> num_avg == 14'h04B0;
   endproperty
   a_code_slow: assert property (p_code_slow) else $error("code 43 decode wrong"); // R7
   property p_code_min;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rate_code_field == CODE_A12000) |-> num_avg == 14'h2EE0;
   endproperty
   a_code_min: assert property (p_code_min) else $error("code 03 decode wrong"); // R8
   property p_cal_route;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      (wr_ctrl && avs_writedata_i[CTRL_CAL_BIT]) |=> mux_all_open_o && route_neg_ref_to_neg_in_o
                                                   && route_pos_ref_to_pos_in_o;
   endproperty
   a_cal_route: assert property (p_cal_route) else $error("calibration routing missing"); // R10
   property p_sync_ready;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      restart |=> result_ready_n_o ##1 result_ready_n_o;
   endproperty
   a_sync_ready: assert property (p_sync_ready) else $error("ready active after sync"); // R11
   property p_rate_clear;
      @(posedge ref_clk_i) disable iff (sys_rst_i)
      rate_accept |=> avg_cnt == '0 && avg_sum == '0 && state == ST_IDLE;
   endproperty
   a_rate_clear: assert property (p_rate_clear) else $error("averager not cleared"); // R12

   c_bypass_word: cover property (@(posedge ref_clk_i) push_done && num_avg == 14'h0001);
   c_divided_word: cover property (@(posedge ref_clk_i) push_done && num_avg != 14'h0001);
   c_fifo_full: cover property (@(posedge ref_clk_i) !fifo_in_ready);
   c_ready_fall: cover property (@(posedge ref_clk_i) $fell(result_ready_n_o));
endmodule
`default_nettype wire

// >>> src/sinc_filter_pkg.sv
package sinc_filter_pkg;

   // ------------------------------------------------------------------
   // Filter structure.
   // ------------------------------------------------------------------
   localparam int CIC_ORDER = 5;
   localparam int SAMPLE_DIV = 4;
   localparam int DECIM = 64;
   localparam int FIXED_PERIOD = SAMPLE_DIV * DECIM;
   localparam int CIC_W = 31;
   localparam int ACC_W = 44;
   localparam int AVG_W = 14;
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int LEVEL_W = 5;
   localparam int GAP_W = 24;
   localparam int STEP_W = 6;
   localparam int ADDR_W = 4;

   // ------------------------------------------------------------------
   // Register map (byte addresses) and field positions.
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_RATE = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_RESULT = 4'hC;
   localparam logic [7:0] RATE_RESET = 8'hF0;
   localparam int CTRL_CAL_BIT = 0;
   localparam int CTRL_SYNC_BIT = 1;
   localparam int ST_READY_BIT = 0;
   localparam int ST_OVERRUN_BIT = 1;
   localparam int ST_REJECT_BIT = 2;
   localparam int ST_SETTLED_BIT = 3;
   localparam int ST_LEVEL_LSB = 8;

   // ------------------------------------------------------------------
   // Rate codes.
   // ------------------------------------------------------------------
   localparam logic [7:0] CODE_A1 = 8'hF0;
   localparam logic [7:0] CODE_A2 = 8'hE0;
   localparam logic [7:0] CODE_A4 = 8'hD0;
   localparam logic [7:0] CODE_A8 = 8'hC0;
   localparam logic [7:0] CODE_A15 = 8'hB0;
   localparam logic [7:0] CODE_A30 = 8'hA1;
   localparam logic [7:0] CODE_A60 = 8'h92;
   localparam logic [7:0] CODE_A300 = 8'h82;
   localparam logic [7:0] CODE_A500 = 8'h72;
   localparam logic [7:0] CODE_A600 = 8'h63;
   localparam logic [7:0] CODE_A1000 = 8'h53;
   localparam logic [7:0] CODE_A1200 = 8'h43;
   localparam logic [7:0] CODE_A2000 = 8'h33;
   localparam logic [7:0] CODE_A3000 = 8'h23;
   localparam logic [7:0] CODE_A6000 = 8'h13;
   localparam logic [7:0] CODE_A12000 = 8'h03;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DIVIDE = 3'b010,
      ST_PUSH = 3'b100
   } div_state_t;

   // Averaging count for a rate code; zero marks an invalid code.
   function automatic logic [AVG_W-1:0] avg_count(input logic [7:0] code);
      case (code)
         CODE_A1: return 14'h0001;
         CODE_A2: return 14'h0002;
         CODE_A4: return 14'h0004;
         CODE_A8: return 14'h0008;
         CODE_A15: return 14'h000F;
         CODE_A30: return 14'h001E;
         CODE_A60: return 14'h003C;
         CODE_A300: return 14'h012C;
         CODE_A500: return 14'h01F4;
         CODE_A600: return 14'h0258;
         CODE_A1000: return 14'h03E8;
         CODE_A1200: return 14'h04B0;
         CODE_A2000: return 14'h07D0;
         CODE_A3000: return 14'h0BB8;
         CODE_A6000: return 14'h1770;
         CODE_A12000: return 14'h2EE0;
         default: return 14'h0000;
      endcase
   endfunction

endpackage

// >>> tb/mod_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------
// Behavioural one-bit modulator.
// --------------------------------------------------
module mod_model (
   // Clock and density select.
   input wire logic clk_i,
   input wire logic ones_i,
   // Modulator stream.
   output logic bit_o
);
   // A constant density keeps every settled mean exact, so words are predictable.
   initial bit_o = 1'b0;
   always @(posedge clk_i) begin
      bit_o <= ones_i;
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
   import sinc_filter_pkg::*;
   // --------------------------------------------------
   // Stimulus signals and counters.
   // --------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, sync_pin = 1'b0, rd = 1'b0, wr = 1'b0, rdy = 1'b1, ones = 1'b1;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, data;
   logic wreq, valid, ready_n, mux_open, neg_rt, pos_rt, mbit, rdyn_low;
   logic [31:0] q, d;
   int fail_count = 0, check_count = 0, cyc = 0, t0, t1, t2, n;
   logic [7:0] codes [16] = '{CODE_A1, CODE_A2, CODE_A4, CODE_A8, CODE_A15, CODE_A30, CODE_A60, CODE_A300,
      CODE_A500, CODE_A600, CODE_A1000, CODE_A1200, CODE_A2000, CODE_A3000, CODE_A6000, CODE_A12000};
   // The 20 MHz master clock and a cycle count for timing words.
   always #25 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   mod_model u_mod (.clk_i(clk), .ones_i(ones), .bit_o(mbit));
   sinc_decimation_filter uut (.ref_clk_i(clk), .sys_rst_i(rst), .mod_bit_i(mbit), .sync_powerdown_pin_i(sync_pin),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .result_data_o(data), .result_valid_o(valid), .result_ready_i(rdy),
      .result_ready_n_o(ready_n), .mux_all_open_o(mux_open), .route_neg_ref_to_neg_in_o(neg_rt),
      .route_pos_ref_to_pos_in_o(pos_rt));
   // --------------------------------------------------
   // Bus and stream tasks.
   // --------------------------------------------------
   // The request is held until waitrequest is sampled low, for at most 100 cycles.
   task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] v, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      addr <= a;
      wdata <= v;
      rd <= ~we;
      wr <= we;
      do begin
         @(posedge clk);
         k++;
      end while (wreq !== 1'b0 && k < 100);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      `CHK("bus answer", 1'b0, wreq)
   endtask
   task automatic wrt(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      logic [31:0] r;
      bus(1'b1, a, v, r);
   endtask
   task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, r, r);
      `CHK(nm, e, r)
   endtask
   // Waits for one word, noting whether the ready output fell before it.
   task automatic word(output logic [31:0] w, output int t);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (valid !== 1'b1 && ready_n !== 1'b1) rdyn_low = 1'b1;
      end while (valid !== 1'b1 && k < 20000);
      w = data;
      t = cyc;
      `CHK("word", 32'h40000000, w)
   endtask
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // --------------------------------------------------
   // Tests.
   // --------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc("rate reset", OFF_RATE, 32'h000000F0);
      rdc("unmapped", 4'h2, 32'h00000000);
      `CHK("route reset", 3'h0, {mux_open, neg_rt, pos_rt})
      $display("Test reset done");
      // Every valid code is kept; a bad one is refused and flagged.
      foreach (codes[i]) begin
         wrt(OFF_RATE, {24'h0, codes[i]});
         rdc("rate code", OFF_RATE, {24'h0, codes[i]});
      end
      wrt(OFF_RATE, 32'h00000055);
      rdc("rate kept", OFF_RATE, 32'h00000003);
      bus(1'b0, OFF_STATUS, q, q);
      `CHK("reject flag", 1'b1, q[ST_REJECT_BIT])
      wrt(OFF_RATE, 32'h000000F0);
      bus(1'b0, OFF_STATUS, q, q);
      `CHK("reject clear", 1'b0, q[ST_REJECT_BIT])
      $display("Test codes done");
      // The write lands at the edge the task returns on, so the routing is looked at one edge later.
      wrt(OFF_CTRL, 32'h00000001);
      @(posedge clk);
      `CHK("cal route", 3'h7, {mux_open, neg_rt, pos_rt})
      wrt(OFF_CTRL, 32'h00000002);
      rdc("soft sync", OFF_CTRL, 32'h00000002);
      `CHK("sync ready", 1'b1, ready_n)
      wrt(OFF_CTRL, 32'h00000000);
      @(posedge clk);
      `CHK("cal off", 3'h0, {mux_open, neg_rt, pos_rt})
      $display("Test calibration done");
      // A sync restarts the filter; the first word arrives only when settled.
      sync_pin <= 1'b1;
      repeat (4) @(posedge clk);
      sync_pin <= 1'b0;
      t0 = cyc;
      rdyn_low = 1'b0;
      word(d, t1);
      `CHK("settle time", 1'b1, (t1 - t0) >= 6 * FIXED_PERIOD)
      `CHK("early ready", 1'b0, rdyn_low)
      word(d, t2);
      `CHK("rate 1", FIXED_PERIOD, t2 - t1)
      // A code write restarts the averager; spacing then follows the new count.
      wrt(OFF_RATE, 32'h000000E0);
      word(d, t1);
      word(d, t2);
      `CHK("rate 2", 2 * FIXED_PERIOD, t2 - t1)
      wrt(OFF_RATE, 32'h000000D0);
      word(d, t1);
      word(d, t2);
      `CHK("rate 4", 4 * FIXED_PERIOD, t2 - t1)
      rdc("result reg", OFF_RESULT, 32'h40000000);
      $display("Test rates done");
      // The sink stalls until the buffer refuses, then drains it.
      wrt(OFF_RATE, 32'h000000F0);
      rdy <= 1'b0;
      repeat (19 * FIXED_PERIOD) @(posedge clk);
      bus(1'b0, OFF_STATUS, q, q);
      `CHK("level full", 5'd16, q[ST_LEVEL_LSB+:5])
      `CHK("overrun", 1'b1, q[ST_OVERRUN_BIT])
      `CHK("settled", 1'b1, q[ST_SETTLED_BIT])
      `CHK("ready pin", 1'b0, ready_n)
      rdy <= 1'b1;
      n = 0;
      repeat (24) begin
         @(posedge clk);
         if (valid === 1'b1) n++;
      end
      `CHK("drained", 17, n)
      bus(1'b0, OFF_STATUS, q, q);
      `CHK("level empty", 5'd0, q[ST_LEVEL_LSB+:5])
      `CHK("overrun clear", 1'b0, q[ST_OVERRUN_BIT])
      $display("Test buffer done");
      end_sim;
   end
   // The tests need about 10000 cycles; this limit is well beyond that.
   initial begin
      repeat (80000) @(posedge clk);
      fail_count++;
      $display("MISMATCH watchdog expected 0 seen 1");
      end_sim;
   end
endmodule
`default_nettype wire
